// File: hw/two_wire_master_port.sv
`timescale 1ns/1ns
`default_nettype none

module two_wire_master_port (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_ce,
    input  wire logic                  i_start,
    input  wire two_wire_pkg::cmd_t    i_cmd,
    input  wire logic [127:0]          i_wr_data,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_scl_o,
    output logic                       o_scl_oe,
    output logic                       o_sda_o,
    output logic                       o_sda_oe,
    output two_wire_pkg::status_t      o_status,
    output logic [127:0]               o_rd_data
);

    // =====================================================================
    // reset release
    logic [1:0] rst_sync_r;
    logic       rst_b;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // =====================================================================
    // state
    two_wire_pkg::state_t  state_r;
    two_wire_pkg::cmd_t    cmd_r;
    two_wire_pkg::status_t status_r;
    logic [1:0]            qtr_r, seg_r;
    logic [9:0]            div_r;
    logic [3:0]            bit_r, wr_idx_r, rd_idx_r;
    logic [4:0]            left_r;
    logic [7:0]            shift_r;
    logic [127:0]          wbuf_r, rbuf_r;
    logic                  rx_bit_r, scl_oe_r, sda_oe_r, low_r;

    // =====================================================================
    // decode
    logic       tick, qtr_end, sample, first_rd, two_phase, seg_rd, is_addr, rx_byte;
    logic       byte_end, nack_hit, last_in_seg, go_rstart, go_data, accept;
    logic       scl_low, sda_low;
    logic [4:0] seg_cnt;
    logic [9:0] qtr_len;

    assign tick      = (div_r == two_wire_pkg::DIV_RST);
    assign qtr_end   = tick && (qtr_r == two_wire_pkg::LAST_QTR);
    assign sample    = tick && (qtr_r == two_wire_pkg::SAMPLE_QTR);
    assign first_rd  = (cmd_r.xfer == two_wire_pkg::XFER_READ)
                    || (cmd_r.xfer == two_wire_pkg::XFER_RD_WR);
    assign two_phase = cmd_r.xfer[1];
    assign seg_rd    = seg_r[1] ? !first_rd : first_rd;
    assign is_addr   = !seg_r[0];
    assign rx_byte   = !is_addr && seg_rd;
    assign seg_cnt   = seg_rd ? cmd_r.rd_cnt : cmd_r.wr_cnt;
    assign accept    = i_start && (state_r == two_wire_pkg::ST_IDLE);
    assign byte_end  = (state_r == two_wire_pkg::ST_BYTE) && qtr_end
                    && (bit_r == two_wire_pkg::ACK_BIT);
    // no arbitration or lost-bus check: the bus is ours alone
    assign nack_hit  = !rx_byte && rx_bit_r;
    assign last_in_seg = is_addr ? (seg_cnt == 5'h00) : (left_r == 5'h01);
    assign go_rstart = !nack_hit && last_in_seg && !seg_r[1] && two_phase;
    assign go_data   = !nack_hit && !last_in_seg;

    always_comb begin
        unique case (cmd_r.rate)
            two_wire_pkg::RATE_100K: qtr_len = two_wire_pkg::QTR_RATE0;
            two_wire_pkg::RATE_400K: qtr_len = two_wire_pkg::QTR_RATE1;
            two_wire_pkg::RATE_800K: qtr_len = two_wire_pkg::QTR_RATE2;
            two_wire_pkg::RATE_1M:   qtr_len = two_wire_pkg::QTR_RATE3;
        endcase
    end

    // =====================================================================
    // pin levels; sda moves after scl has been low for a quarter, except the start and stop edges, which move it in the last quarter with scl high
    always_comb begin
        scl_low = 1'b0;
        sda_low = sda_oe_r;
        unique case (state_r)
            two_wire_pkg::ST_IDLE: begin
                sda_low = 1'b0;
            end
            two_wire_pkg::ST_START: begin
                scl_low = (qtr_r < 2'h2);
                if (qtr_r != 2'h0) begin
                    sda_low = (qtr_r == two_wire_pkg::LAST_QTR);
                end
            end
            two_wire_pkg::ST_BYTE: begin
                scl_low = (qtr_r < 2'h2);
                if (qtr_r != 2'h0) begin
                    if (bit_r == two_wire_pkg::ACK_BIT) begin
                        sda_low = rx_byte && (left_r != 5'h01);
                    end else begin
                        sda_low = !rx_byte && !shift_r[7];
                    end
                end
            end
            two_wire_pkg::ST_STOP: begin
                scl_low = (qtr_r < 2'h2);
                if (qtr_r != 2'h0) begin
                    sda_low = (qtr_r != two_wire_pkg::LAST_QTR);
                end
            end
        endcase
    end

    // open drain: the driven level is a constant low
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            low_r    <= 1'b0;
        end else if (i_ce) begin
            scl_oe_r <= scl_low;
            sda_oe_r <= sda_low;
            low_r    <= 1'b0;
        end
    end

    // =====================================================================
    // bit timing; scl is never read back, so a stretching slave is ignored
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= two_wire_pkg::DIV_RST;
            qtr_r <= 2'h0;
        end else if (i_ce) begin
            if (state_r == two_wire_pkg::ST_IDLE) begin
                div_r <= two_wire_pkg::DIV_RST;
                qtr_r <= 2'h0;
            end else if (tick) begin
                div_r <= qtr_len - 10'h001;
                qtr_r <= qtr_r + 2'h1;
            end else begin
                div_r <= div_r - 10'h001;
            end
        end
    end

    // =====================================================================
    // sequencer
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= two_wire_pkg::ST_IDLE;
            seg_r   <= two_wire_pkg::SEG_ADDR1;
            bit_r   <= 4'h0;
            left_r  <= 5'h00;
        end else if (i_ce) begin
            unique case (state_r)
                two_wire_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_r <= two_wire_pkg::ST_START;
                        seg_r   <= two_wire_pkg::SEG_ADDR1;
                    end
                end
                two_wire_pkg::ST_START: begin
                    if (qtr_end) begin
                        state_r <= two_wire_pkg::ST_BYTE;
                        bit_r   <= 4'h0;
                    end
                end
                two_wire_pkg::ST_BYTE: begin
                    if (byte_end) begin
                        bit_r <= 4'h0;
                        if (go_data) begin
                            seg_r[0] <= 1'b1;
                            left_r   <= is_addr ? seg_cnt : left_r - 5'h01;
                        end else if (go_rstart) begin
                            state_r <= two_wire_pkg::ST_START;
                            seg_r   <= two_wire_pkg::SEG_ADDR2;
                        end else begin
                            state_r <= two_wire_pkg::ST_STOP;
                        end
                    end else if (qtr_end) begin
                        bit_r <= bit_r + 4'h1;
                    end
                end
                two_wire_pkg::ST_STOP: begin
                    if (qtr_end) begin
                        state_r <= two_wire_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // command capture; counts above sixteen are clipped
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r  <= '0;
            wbuf_r <= '0;
        end else if (i_ce && accept) begin
            cmd_r <= i_cmd;
            if (i_cmd.wr_cnt > two_wire_pkg::MAX_BYTES) begin
                cmd_r.wr_cnt <= two_wire_pkg::MAX_BYTES;
            end
            if (i_cmd.rd_cnt > two_wire_pkg::MAX_BYTES) begin
                cmd_r.rd_cnt <= two_wire_pkg::MAX_BYTES;
            end
            wbuf_r <= i_wr_data;
        end
    end

    // =====================================================================
    // byte shifter and data buffers
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r  <= two_wire_pkg::BYTE_RST;
            rx_bit_r <= 1'b1;
            wr_idx_r <= 4'h0;
            rd_idx_r <= 4'h0;
            rbuf_r   <= '0;
        end else if (i_ce) begin
            if (accept) begin
                wr_idx_r <= 4'h0;
                rd_idx_r <= 4'h0;
            end
            if (sample) begin
                rx_bit_r <= i_sda;
            end
            if (state_r == two_wire_pkg::ST_START && qtr_end) begin
                shift_r <= {cmd_r.addr, seg_rd};
            end else if (byte_end) begin
                if (rx_byte) begin
                    rbuf_r[{rd_idx_r, 3'h0} +: 8] <= shift_r;
                    rd_idx_r <= rd_idx_r + 4'h1;
                end
                if (go_data && !seg_rd) begin
                    shift_r  <= wbuf_r[{wr_idx_r, 3'h0} +: 8];
                    wr_idx_r <= wr_idx_r + 4'h1;
                end
            end else if (state_r == two_wire_pkg::ST_BYTE && tick && qtr_r == 2'h0
                         && bit_r != 4'h0) begin
                shift_r <= {shift_r[6:0], rx_bit_r};
            end
        end
    end

    // =====================================================================
    // status; nack only sets while busy and only clears on a new start
    always_ff @(posedge i_mclk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= '0;
        end else if (i_ce) begin
            status_r.done <= (state_r == two_wire_pkg::ST_STOP) && qtr_end;
            if (accept) begin
                status_r.busy <= 1'b1;
                status_r.nack <= 1'b0;
            end else if ((state_r == two_wire_pkg::ST_STOP) && qtr_end) begin
                status_r.busy <= 1'b0;
            end
            if (byte_end && nack_hit) begin
                status_r.nack <= 1'b1;
            end
        end
    end

    assign o_scl_o   = low_r;
    assign o_sda_o   = low_r;
    assign o_scl_oe  = scl_oe_r;
    assign o_sda_oe  = sda_oe_r;
    assign o_status  = status_r;
    assign o_rd_data = rbuf_r;

    // =====================================================================
    // checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!rst_b);

    idle_release_a: assert property (
        !o_status.busy |-> !o_scl_oe && !o_sda_oe)
        else $error("pins driven while idle");
    pins_low_a: assert property (
        !o_scl_o && !o_sda_o)
        else $error("pin driven high");
    start_busy_a: assert property (
        accept && i_ce |=> o_status.busy && state_r == two_wire_pkg::ST_START)
        else $error("start not taken");
    nack_stop_a: assert property (
        byte_end && nack_hit && i_ce |=> state_r == two_wire_pkg::ST_STOP && o_status.nack)
        else $error("nack not followed by stop");
    rstart_seg_a: assert property (
        byte_end && go_rstart && i_ce
        |=> state_r == two_wire_pkg::ST_START && seg_r == two_wire_pkg::SEG_ADDR2)
        else $error("no repeated start between phases");
    rd_ack_a: assert property (
        state_r == two_wire_pkg::ST_BYTE && bit_r == two_wire_pkg::ACK_BIT && rx_byte
        && qtr_r != 2'h0 && i_ce |=> o_sda_oe == ($past(left_r) != 5'h01))
        else $error("wrong read acknowledge");
    start_cond_a: assert property (
        state_r == two_wire_pkg::ST_START && qtr_r == two_wire_pkg::LAST_QTR && i_ce
        |=> o_sda_oe && !o_scl_oe)
        else $error("bad start condition");
    quarter_len_a: assert property (
        state_r != two_wire_pkg::ST_IDLE && tick && i_ce |=> div_r == $past(qtr_len) - 10'h001)
        else $error("quarter period wrong");
    count_bound_a: assert property (
        left_r <= two_wire_pkg::MAX_BYTES && cmd_r.rd_cnt <= two_wire_pkg::MAX_BYTES)
        else $error("byte count above sixteen");
    done_stop_a: assert property (
        o_status.done |-> $past(state_r) == two_wire_pkg::ST_STOP && !o_status.busy)
        else $error("done without stop");

    rstart_seen_c: cover property (byte_end && go_rstart && i_ce);
    nack_seen_c: cover property (byte_end && nack_hit && i_ce);
    last_read_c: cover property (byte_end && rx_byte && left_r == 5'h01 && i_ce);
    stretch_seen_c: cover property (state_r == two_wire_pkg::ST_BYTE && qtr_r == 2'h3 && !i_scl);

endmodule : two_wire_master_port
`default_nettype wire

// File: hw/two_wire_pkg.sv
package two_wire_pkg;

    // =====================================================================
    // clock and bus rates
    localparam int unsigned CLK_KHZ   = 125000;
    localparam int unsigned RATE0_KHZ = 100;
    localparam int unsigned RATE1_KHZ = 400;
    localparam int unsigned RATE2_KHZ = 800;
    localparam int unsigned RATE3_KHZ = 1000;

    // quarter bit periods, rounded up so the bus never runs fast
    localparam logic [9:0] QTR_RATE0 = 10'((CLK_KHZ + 4 * RATE0_KHZ - 1) / (4 * RATE0_KHZ));
    localparam logic [9:0] QTR_RATE1 = 10'((CLK_KHZ + 4 * RATE1_KHZ - 1) / (4 * RATE1_KHZ));
    localparam logic [9:0] QTR_RATE2 = 10'((CLK_KHZ + 4 * RATE2_KHZ - 1) / (4 * RATE2_KHZ));
    localparam logic [9:0] QTR_RATE3 = 10'((CLK_KHZ + 4 * RATE3_KHZ - 1) / (4 * RATE3_KHZ));

    // =====================================================================
    // rate select and transfer kinds
    localparam logic [1:0] RATE_100K  = 2'h0;
    localparam logic [1:0] RATE_400K  = 2'h1;
    localparam logic [1:0] RATE_800K  = 2'h2;
    localparam logic [1:0] RATE_1M    = 2'h3;
    localparam logic [1:0] XFER_READ  = 2'h0;
    localparam logic [1:0] XFER_WRITE = 2'h1;
    localparam logic [1:0] XFER_RD_WR = 2'h2;
    localparam logic [1:0] XFER_WR_RD = 2'h3;

    // =====================================================================
    // counts, positions, reset values
    localparam logic [4:0] MAX_BYTES  = 5'h10;
    localparam logic [3:0] ACK_BIT    = 4'h8;
    localparam logic [1:0] SAMPLE_QTR = 2'h2;
    localparam logic [1:0] LAST_QTR   = 2'h3;
    localparam logic [1:0] SEG_ADDR1  = 2'h0;
    localparam logic [1:0] SEG_ADDR2  = 2'h2;
    localparam logic [9:0] DIV_RST    = 10'h000;
    localparam logic [7:0] BYTE_RST   = 8'h00;

    // =====================================================================
    // carriers and states
    typedef struct packed {
        logic [1:0] xfer;
        logic [1:0] rate;
        logic [6:0] addr;
        logic [4:0] wr_cnt;
        logic [4:0] rd_cnt;
    } cmd_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic nack;
    } status_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_BYTE  = 2'b10,
        ST_STOP  = 2'b11
    } state_t;

endpackage : two_wire_pkg

// File: test/test_two_wire_master_port.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// bench for the two-wire master port
module test_two_wire_master_port;
    localparam logic [6:0] SLV = 7'h50;
    localparam logic [7:0] RDB = 8'ha5;

    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  start = 1'b0;
    logic                  clr = 1'b0;
    two_wire_pkg::cmd_t    cmd = '0;
    logic [127:0]          wr_data = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    logic                  scl_o, scl_oe, sda_o, sda_oe, slv_oe;
    two_wire_pkg::status_t status;
    logic [127:0]          rd_data, wr_log;
    logic [7:0]            n_start, n_stop, n_wr, n_mack;
    wire                   scl_w = ~scl_oe;            // pull-up, slave never holds scl
    wire                   sda_w = ~(sda_oe | slv_oe); // pull-up, wired-and
    logic                  scl_q = 1'b1;
    int                    cyc = 0;
    int                    nrise = 0;
    int                    t_a = 0;
    int                    t_b = 0;
    int                    n_drv = 0;
    int                    n_mismatch = 0;
    int                    comparisons = 0;

    two_wire_master_port uut (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(1'b1), .i_start(start),
        .i_cmd(cmd), .i_wr_data(wr_data), .i_scl(scl_w), .i_sda(sda_w), .o_scl_o(scl_o),
        .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_status(status),
        .o_rd_data(rd_data));

    two_wire_slave_model #(.DEV_ADDR(SLV), .RD_BASE(RDB)) slave (.i_mclk(mclk), .i_clr(clr),
        .i_scl(scl_w), .i_sda(sda_w), .o_sda_oe(slv_oe), .o_wr_log(wr_log),
        .o_n_start(n_start), .o_n_stop(n_stop), .o_n_wr(n_wr), .o_n_mack(n_mack));

    always #4 mclk = ~mclk;

    // =====================================================================
    // wire watch: rise times, drive level, hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        scl_q <= scl_w;
        // outputs are unknown until reset has reached the flops
        if (rst_b && (scl_o !== 1'b0 || sda_o !== 1'b0)) n_drv <= n_drv + 1;
        if (scl_w && !scl_q) begin
            nrise <= nrise + 1;
            if (nrise == 1) t_a <= cyc;
            if (nrise == 2) t_b <= cyc;
        end
        if (clr) nrise <= 0;
        if (cyc == 95000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // =====================================================================
    // compare and sequence helpers
    task automatic cmp_num(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp_num

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp_byte

    // poke: a second start while busy must be ignored
    task automatic do_xfer(input logic [1:0] kind, input logic [1:0] rate, input logic [6:0] adr,
                           input logic [4:0] wc, input logic [4:0] rc, input logic poke);
        int n;
        @(posedge mclk);
        cmd <= '{xfer: kind, rate: rate, addr: adr, wr_cnt: wc, rd_cnt: rc};
        start <= 1'b1;
        clr <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        clr <= 1'b0;
        @(posedge mclk);
        cmp_num("busy", 32'h1, {31'h0, status.busy});
        n = 0;
        while (status.done !== 1'b1 && n < 40000) begin
            if (poke && n == 100) start <= 1'b1;
            if (poke && n == 101) start <= 1'b0;
            @(posedge mclk);
            n++;
        end
        cmp_num("done", 32'h1, {31'h0, status.done});
        @(posedge mclk);
        cmp_num("busy_end", 32'h0, {31'h0, status.busy});
    endtask : do_xfer

    task automatic chk_bytes(input int nw, input int nr);
        cmp_num("written", nw, {24'h0, n_wr});
        for (int k = 0; k < nw; k++) cmp_byte("wr_byte", wr_data[8*k +: 8], wr_log[8*k +: 8]);
        for (int k = 0; k < nr; k++) cmp_byte("rd_byte", RDB + 8'(k), rd_data[8*k +: 8]);
        if (nr > 0) cmp_num("master_acks", nr - 1, {24'h0, n_mack});
    endtask : chk_bytes

    // =====================================================================
    // scenarios
    task automatic t_rates;
        logic [9:0] q [4];
        q = '{two_wire_pkg::QTR_RATE0, two_wire_pkg::QTR_RATE1,
              two_wire_pkg::QTR_RATE2, two_wire_pkg::QTR_RATE3};
        for (int r = 0; r < 4; r++) begin
            do_xfer(two_wire_pkg::XFER_WRITE, 2'(r), SLV, 5'h00, 5'h00, 1'b0);
            cmp_num("bit_period", 4 * q[r], t_b - t_a);
            cmp_num("stops", 32'h1, {24'h0, n_stop});
            cmp_num("nack", 32'h0, {31'h0, status.nack});
        end
    endtask : t_rates

    task automatic t_write16;
        // twenty asked, sixteen must go out
        do_xfer(two_wire_pkg::XFER_WRITE, two_wire_pkg::RATE_1M, SLV, 5'h14, 5'h00, 1'b1);
        chk_bytes(16, 0);
        cmp_num("starts", 32'h1, {24'h0, n_start});
    endtask : t_write16

    task automatic t_read16;
        do_xfer(two_wire_pkg::XFER_READ, two_wire_pkg::RATE_1M, SLV, 5'h00, 5'h10, 1'b0);
        chk_bytes(0, 16);
        cmp_num("stops", 32'h1, {24'h0, n_stop});
    endtask : t_read16

    task automatic t_wr_rd;
        do_xfer(two_wire_pkg::XFER_WR_RD, two_wire_pkg::RATE_1M, SLV, 5'h02, 5'h03, 1'b0);
        chk_bytes(2, 3);
        cmp_num("starts", 32'h2, {24'h0, n_start});
        cmp_num("stops", 32'h1, {24'h0, n_stop});
    endtask : t_wr_rd

    task automatic t_rd_wr;
        do_xfer(two_wire_pkg::XFER_RD_WR, two_wire_pkg::RATE_1M, SLV, 5'h01, 5'h02, 1'b0);
        chk_bytes(1, 2);
        cmp_num("starts", 32'h2, {24'h0, n_start});
        cmp_num("stops", 32'h1, {24'h0, n_stop});
    endtask : t_rd_wr

    task automatic t_nack;
        do_xfer(two_wire_pkg::XFER_WRITE, two_wire_pkg::RATE_1M, 7'h23, 5'h02, 5'h00, 1'b0);
        cmp_num("nack", 32'h1, {31'h0, status.nack});
        cmp_num("stops", 32'h1, {24'h0, n_stop});
        cmp_num("written", 32'h0, {24'h0, n_wr});
    endtask : t_nack

    task automatic tally_and_finish;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp_num("status_rst", 32'h0, {29'h0, status});
        cmp_num("scl_idle", 32'h0, {31'h0, scl_oe});
        t_rates();
        t_write16();
        t_read16();
        t_wr_rd();
        t_rd_wr();
        t_nack();
        cmp_num("drive_high", 32'h0, n_drv);
        tally_and_finish();
    end
endmodule : test_two_wire_master_port
`default_nettype wire

// File: test/two_wire_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// behavioural slave on the far side of the two-wire port
module two_wire_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50,
    parameter logic [7:0] RD_BASE  = 8'ha5
) (
    input  wire logic         i_mclk,
    input  wire logic         i_clr,
    input  wire logic         i_scl,
    input  wire logic         i_sda,
    output logic              o_sda_oe,
    output logic [127:0]      o_wr_log,
    output logic [7:0]        o_n_start,
    output logic [7:0]        o_n_stop,
    output logic [7:0]        o_n_wr,
    output logic [7:0]        o_n_mack
);
    // no scl output: the model never stretches the clock
    logic       scl_q   = 1'b1;
    logic       sda_q   = 1'b1;
    logic       sel     = 1'b0;
    logic       rd      = 1'b0;
    logic       in_addr = 1'b0;
    logic       adr_ack = 1'b0;
    logic       oe      = 1'b0;
    logic [3:0] bitn    = 4'h0;
    logic [7:0] sh      = 8'h00;
    logic [7:0] rk      = 8'h00;
    logic [7:0] rb;

    initial begin
        o_sda_oe  = 1'b0;
        o_wr_log  = '0;
        o_n_start = 8'h00;
        o_n_stop  = 8'h00;
        o_n_wr    = 8'h00;
        o_n_mack  = 8'h00;
    end

    // sda only moves one cycle after scl falls, so the master sees a clean bit
    always @(posedge i_mclk) begin
        rb = RD_BASE + rk;
        if (i_clr) begin
            o_wr_log  <= '0;
            o_n_start <= 8'h00;
            o_n_stop  <= 8'h00;
            o_n_wr    <= 8'h00;
            o_n_mack  <= 8'h00;
        end
        if (scl_q && i_scl && sda_q && !i_sda) begin // start seen
            o_n_start <= o_n_start + 8'h01;
            bitn = 4'h0;
            in_addr = 1'b1;
            adr_ack = 1'b0;
            sel = 1'b0;
            rk = 8'h00;
            oe = 1'b0;
        end else if (scl_q && i_scl && !sda_q && i_sda) begin // stop seen
            o_n_stop <= o_n_stop + 8'h01;
            sel = 1'b0;
            oe = 1'b0;
        end else if (!scl_q && i_scl) begin
            if (bitn < 4'h8) begin
                sh = {sh[6:0], i_sda}; // msb first
            end else if (adr_ack) begin // own address ack, not a master ack
                adr_ack = 1'b0;
            end else if (sel && rd) begin
                if (!i_sda) begin // master ack of a read byte
                    o_n_mack <= o_n_mack + 8'h01;
                end else begin
                    sel = 1'b0;
                end
            end
            bitn = bitn + 4'h1;
        end else if (scl_q && !i_scl) begin
            if (bitn == 4'h9) begin
                bitn = 4'h0;
                oe = sel && rd && !rb[7];
            end else if (bitn == 4'h8) begin
                if (in_addr) begin // address plus direction, ack on match
                    sel = (sh[7:1] == DEV_ADDR);
                    rd = sh[0];
                    in_addr = 1'b0;
                    adr_ack = 1'b1;
                    oe = sel;
                end else if (sel && !rd) begin // ack every written byte
                    o_wr_log[8 * o_n_wr +: 8] <= sh;
                    o_n_wr <= o_n_wr + 8'h01;
                    oe = 1'b1;
                end else begin
                    if (sel) rk = rk + 8'h01;
                    oe = 1'b0;
                end
            end else begin
                oe = sel && rd && !rb[3'h7 - bitn[2:0]];
            end
        end
        scl_q = i_scl;
        sda_q = i_sda;
        o_sda_oe <= oe;
    end
endmodule : two_wire_slave_model
`default_nettype wire
